//--- gsr_port.v
`timescale 1ns/1ps
`default_nettype none
`include "gsr_defs.vh"
module gsr_port #(
  parameter PINS = 8,
  parameter [7:0] REV_MAJOR = 8'h05, // arbitrary value
  parameter [7:0] REV_MINOR = 8'h12  // arbitrary value
) (
  input wire i_clk,
  input wire i_rst_b,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire [PINS-1:0] i_pin_in,
  output wire [PINS-1:0] o_pin_out,
  output wire [PINS-1:0] o_pin_oe,
  input wire i_edge_input_pin,
  output reg o_irq_b
);
  // revision readout steps
  localparam [1:0] REV_DUMMY = 2'd0;
  localparam [1:0] REV_MSB = 2'd1;
  localparam [1:0] REV_LAST = `GSR_REV_STEPS - 2'd1;
  reg [7:0] pin_level_state_reg;
  reg [7:0] pin_level_state_next;
  reg [15:0] pin_mode_reg;
  reg [15:0] pin_mode_next;
  reg edge_event_flag_reg;
  reg edge_event_flag_next;
  reg edge_irq_enable_reg;
  reg edge_irq_enable_next;
  reg edge_polarity_select_reg;
  reg edge_polarity_select_next;
  reg edge_prev_reg;
  reg edge_seen_reg;
  reg [1:0] rev_step_reg;
  reg [1:0] rev_step_next;
  reg irq_b_next;
  reg [7:0] rdata_next;
  wire sel_pin_state;
  wire sel_mode_lo;
  wire sel_mode_hi;
  wire sel_edge_ctrl;
  wire sel_revision;
  wire wr_pin_state;
  wire wr_mode_lo;
  wire wr_mode_hi;
  wire wr_edge_ctrl;
  wire wr_revision;
  wire rd_revision;
  wire edge_rise;
  wire edge_fall;
  wire edge_hit;
  wire flag_clear;

  function addr_is;
    input [7:0] a;
    input [7:0] off;
    begin
      addr_is = (a == off);
    end
  endfunction

  function [7:0] edge_ctrl_word;
    input f;
    input e;
    input p;
    begin
      edge_ctrl_word = {f, e, p, 5'h00};
    end
  endfunction

  gsr_pin_drv #(.PINS(PINS)) u_drv (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_mode(pin_mode_reg),
    .i_level(pin_level_state_reg),
    .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe)
  );

  // address decode and qualified strobes
  assign sel_pin_state = addr_is(i_addr, `GSR_OFF_PIN_STATE);
  assign sel_mode_lo = addr_is(i_addr, `GSR_OFF_MODE_LO);
  assign sel_mode_hi = addr_is(i_addr, `GSR_OFF_MODE_HI);
  assign sel_edge_ctrl = addr_is(i_addr, `GSR_OFF_EDGE_CTRL);
  assign sel_revision = addr_is(i_addr, `GSR_OFF_REVISION);
  assign wr_pin_state = i_wr & sel_pin_state;
  assign wr_mode_lo = i_wr & sel_mode_lo;
  assign wr_mode_hi = i_wr & sel_mode_hi;
  assign wr_edge_ctrl = i_wr & sel_edge_ctrl;
  assign wr_revision = i_wr & sel_revision;
  assign rd_revision = i_rd & sel_revision;

  // rising when polarity 0, falling when 1
  assign edge_rise = ~edge_prev_reg & i_edge_input_pin;
  assign edge_fall = edge_prev_reg & ~i_edge_input_pin;
  assign edge_hit = edge_seen_reg &
    (edge_polarity_select_reg ? edge_fall : edge_rise);
  assign flag_clear = wr_edge_ctrl & ~i_wdata[`GSR_BIT_FLAG];

  // pin level and mode registers
  always @* begin
    pin_level_state_next = pin_level_state_reg;
    pin_mode_next = pin_mode_reg;
    if (wr_pin_state) begin
      pin_level_state_next = i_wdata;
    end else if (wr_mode_lo) begin
      pin_mode_next[7:0] = i_wdata;
    end else if (wr_mode_hi) begin
      pin_mode_next[15:8] = i_wdata;
    end
  end

  // edge control fields, unused bits dropped
  always @* begin
    edge_irq_enable_next = edge_irq_enable_reg;
    edge_polarity_select_next = edge_polarity_select_reg;
    if (wr_edge_ctrl) begin
      edge_irq_enable_next = i_wdata[`GSR_BIT_ENABLE];
      edge_polarity_select_next = i_wdata[`GSR_BIT_POLARITY];
    end
  end

  // set wins over a same-cycle clear
  always @* begin
    edge_event_flag_next = edge_event_flag_reg;
    if (edge_hit) begin
      edge_event_flag_next = 1'b1;
    end else if (flag_clear) begin
      edge_event_flag_next = 1'b0;
    end
  end

  always @* begin
    irq_b_next = ~((edge_event_flag_reg | edge_hit) & edge_irq_enable_reg);
  end

  // revision sequence: dummy, msb, lsb
  always @* begin
    rev_step_next = rev_step_reg;
    if (wr_revision) begin
      rev_step_next = REV_DUMMY;
    end else if (rd_revision) begin
      case (rev_step_reg)
        REV_DUMMY: rev_step_next = REV_MSB;
        REV_MSB: rev_step_next = REV_LAST;
        default: rev_step_next = REV_DUMMY;
      endcase
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      pin_level_state_reg <= `GSR_RST_BYTE;
      pin_mode_reg <= {2{`GSR_RST_BYTE}};
    end else begin
      pin_level_state_reg <= pin_level_state_next;
      pin_mode_reg <= pin_mode_next;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      edge_event_flag_reg <= 1'b0;
      edge_irq_enable_reg <= 1'b0;
      edge_polarity_select_reg <= 1'b0;
      edge_prev_reg <= 1'b0;
      edge_seen_reg <= 1'b0;
    end else begin
      edge_event_flag_reg <= edge_event_flag_next;
      edge_irq_enable_reg <= edge_irq_enable_next;
      edge_polarity_select_reg <= edge_polarity_select_next;
      edge_prev_reg <= i_edge_input_pin;
      edge_seen_reg <= 1'b1;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      rev_step_reg <= REV_DUMMY;
      o_irq_b <= 1'b1;
    end else begin
      rev_step_reg <= rev_step_next;
      o_irq_b <= irq_b_next;
    end
  end

  always @* begin
    rdata_next = 8'h00;
    if (i_addr == `GSR_OFF_PIN_STATE) begin
      rdata_next = i_pin_in;
    end else if (i_addr == `GSR_OFF_MODE_LO) begin
      rdata_next = pin_mode_reg[7:0];
    end else if (i_addr == `GSR_OFF_MODE_HI) begin
      rdata_next = pin_mode_reg[15:8];
    end else if (i_addr == `GSR_OFF_EDGE_CTRL) begin
      rdata_next = edge_ctrl_word(edge_event_flag_reg, edge_irq_enable_reg,
        edge_polarity_select_reg);
    end else if (i_addr == `GSR_OFF_REVISION) begin
      if (rev_step_reg == REV_MSB) begin
        rdata_next = REV_MAJOR;
      end else if (rev_step_reg == REV_LAST) begin
        rdata_next = REV_MINOR;
      end
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rdata_next;
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule // gsr_port
`default_nettype wire

//--- gsr_defs.vh
`ifndef GSR_DEFS_VH
`define GSR_DEFS_VH
`define GSR_ADDR_W 8
`define GSR_OFF_MODE_LO 8'h00
`define GSR_OFF_PIN_STATE 8'h01
`define GSR_OFF_MODE_HI 8'h07
`define GSR_OFF_EDGE_CTRL 8'h08
`define GSR_OFF_REVISION 8'h40
`define GSR_RST_BYTE 8'h00
`define GSR_BIT_FLAG 7
`define GSR_BIT_ENABLE 6
`define GSR_BIT_POLARITY 5
`define GSR_MODE_OPEN_DRAIN 2'b00
`define GSR_MODE_INPUT 2'b01
`define GSR_MODE_PUSH_PULL 2'b10
`define GSR_MODE_RESERVED 2'b11
`define GSR_REV_STEPS 2'd3
`endif

//--- gsr_pin_drv.v
`timescale 1ns/1ps
`default_nettype none
`include "gsr_defs.vh"
module gsr_pin_drv #(
  parameter PINS = 8
) (
  input wire i_clk,
  input wire i_rst_b,
  input wire [2*PINS-1:0] i_mode,
  input wire [PINS-1:0] i_level,
  output reg [PINS-1:0] o_pin_out,
  output reg [PINS-1:0] o_pin_oe
);
  integer k;
  reg [1:0] m;
  reg [PINS-1:0] out_next;
  reg [PINS-1:0] oe_next;
  always @* begin
    out_next = {PINS{1'b0}};
    oe_next = {PINS{1'b0}};
    m = 2'b00;
    for (k = 0; k < PINS; k = k + 1) begin
      m = i_mode[2*k +: 2];
      case (m)
        `GSR_MODE_OPEN_DRAIN: begin
          out_next[k] = 1'b0;
          oe_next[k] = ~i_level[k];
        end
        `GSR_MODE_PUSH_PULL: begin
          out_next[k] = i_level[k];
          oe_next[k] = 1'b1;
        end
        default: begin
          out_next[k] = 1'b0;
          oe_next[k] = 1'b0;
        end
      endcase
    end
  end
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_pin_out <= {PINS{1'b0}};
      o_pin_oe <= {PINS{1'b0}};
    end else begin
      o_pin_out <= out_next;
      o_pin_oe <= oe_next;
    end
  end
endmodule // gsr_pin_drv
`default_nettype wire

//--- gsr_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module gsr_monitor (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_edge_input_pin,
  input wire logic o_irq_b,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] i_pin_in,
  input wire logic [7:0] o_pin_out,
  input wire logic [7:0] o_pin_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("rdata not idle");
  ctl_rsv_a: assert property ($past(i_rd) && $past(i_addr) == 8'h08 |-> o_rdata[4:0] == 5'h00)
    else $error("unused bits not zero");
  pin_read_a: assert property ($past(i_rd) && $past(i_addr) == 8'h01
    |-> o_rdata == $past(i_pin_in)) else $error("pin read wrong");
  mode_in_a: assert property (i_wr && i_addr == 8'h00 && i_wdata == 8'h55
    |-> ##2 o_pin_oe[3:0] == 4'h0) else $error("input pin driven");
  mode_pp_a: assert property (i_wr && i_addr == 8'h07 && i_wdata == 8'haa
    |-> ##2 o_pin_oe[7:4] == 4'hf) else $error("push-pull pin not driven");
  irq_off_a: assert property (i_wr && i_addr == 8'h08 && !(i_wdata[7] && i_wdata[6])
    && $stable(i_edge_input_pin) ##1 $stable(i_edge_input_pin) |-> ##1 o_irq_b)
    else $error("irq low without flag and enable");
  edge_rise_a: assert property (i_wr && i_addr == 8'h08 && i_wdata[7:5] == 3'b010
    ##1 !i_wr && $rose(i_edge_input_pin) |-> ##[1:2] !o_irq_b) else $error("rise missed");
  edge_fall_a: assert property (i_wr && i_addr == 8'h08 && i_wdata[7:5] == 3'b011
    ##1 !i_wr && $fell(i_edge_input_pin) |-> ##[1:2] !o_irq_b) else $error("fall missed");
endmodule // gsr_monitor
bind gsr_port gsr_monitor u_mon (
  .i_clk(i_clk),
  .i_rst_b(i_rst_b),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .i_edge_input_pin(i_edge_input_pin),
  .o_irq_b(o_irq_b),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .o_rdata(o_rdata),
  .i_pin_in(i_pin_in),
  .o_pin_out(o_pin_out),
  .o_pin_oe(o_pin_oe)
);
`default_nettype wire

//--- gsr_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module gsr_pin_model (
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe,
  input wire logic [7:0] i_ext,
  output logic [7:0] o_pin
);
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext); // driven pins win
endmodule // gsr_pin_model
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_clk = 0, i_rst_b = 0, i_wr = 0, i_rd = 0, ei = 0, o_irq_b;
  logic [7:0] i_addr = 0, i_wdata = 0, ext = 0, o_rdata, pin, pout, poe, l;
  logic [15:0] m;
  integer seed = 30710, err_total = 0, compares = 0, i, p;
  gsr_port #(.REV_MAJOR(8'h02), .REV_MINOR(8'h37)) dut (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pin_in(pin), .o_pin_out(pout), .o_pin_oe(poe), .i_edge_input_pin(ei), .o_irq_b(o_irq_b));
  gsr_pin_model pm (.i_out(pout), .i_oe(poe), .i_ext(ext), .o_pin(pin));
  initial forever #10 i_clk = ~i_clk;
  function [7:0] pexp(input [15:0] md, input [7:0] lv, input [7:0] x);
    integer k;
    for (k = 0; k < 8; k = k + 1) case (md[2*k+:2])
      2'b00: pexp[k] = lv[k] ? x[k] : 1'b0;
      2'b10: pexp[k] = lv[k];
      default: pexp[k] = x[k];
    endcase
  endfunction
  task cyc(input integer n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task chk(input [7:0] g, input [7:0] e);
    compares = compares + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge i_clk) begin i_addr <= a; i_wdata <= d; i_wr <= 1; end
    @(posedge i_clk) i_wr <= 0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(posedge i_clk) begin i_addr <= a; i_rd <= 1; end
    @(posedge i_clk) i_rd <= 0;
    #1 chk(o_rdata, e);
  endtask
  task final_report;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin #100000 err_total = err_total + 1; final_report; end
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1;
    rd(8'h08, 8'h00);
    for (i = 0; i < 5; i = i + 1) begin
      m = i ? $random(seed) : 16'haa55;
      l = i ? $random(seed) : 8'h5a;
      @(posedge i_clk) ext <= $random(seed);
      wr(8'h00, m[7:0]);
      wr(8'h07, m[15:8]);
      wr(8'h01, l);
      cyc(3);
      rd(8'h01, pexp(m, l, ext));
    end
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    wr(8'h08, 8'hbf);
    rd(8'h08, 8'h20);
    for (p = 0; p < 2; p = p + 1) begin
      @(posedge i_clk) ei <= p[0];
      cyc(2);
      wr(8'h08, {2'b01, p[0], 5'h1f});
      ei <= ~p[0];
      cyc(3);
      chk({7'h0, o_irq_b}, 8'h00);
      rd(8'h08, {2'b11, p[0], 5'h00});
      wr(8'h08, {2'b01, p[0], 5'h00});
      cyc(3);
      chk({7'h0, o_irq_b}, 8'h01);
      @(posedge i_clk) ei <= p[0];
      cyc(3);
      rd(8'h08, {2'b01, p[0], 5'h00});
    end
    wr(8'h08, 8'h20);
    ei <= 0;
    cyc(3);
    chk({7'h0, o_irq_b}, 8'h01);
    rd(8'h08, 8'ha0);
    wr(8'h40, 8'h00);
    rd(8'h40, 8'h00);
    rd(8'h40, 8'h02);
    rd(8'h40, 8'h37);
    final_report;
  end
endmodule // tb_top
`default_nettype wire
